// *** acc_dp.sv ***
// Accumulator datapath: adder/subtracter, scaler, overflow and saturation.
// Assumes all inputs except RSTN come from logic on CLK_SYS.
//
// How it works
// [RULE1] 40-bit adder, operand sign-extended to width
// [RULE2] One selected accumulator is source and destination
// [RULE3] Add and load may pre-scale the operand
// [RULE4] Zero on one input, true/complement other
// [RULE5] Add: true operand, carry active-high
// [RULE6] Subtract: complemented operand, borrow active-low
// [RULE7] Carry out of bit 39 is catastrophic
// [RULE8] Guard bits 32..39 unequal means recoverable
// [RULE9] Overflow and saturation flags are latched
// [RULE10] Saturation chosen from result, flags, enables, mode
// [RULE11] Per-accumulator guard overflow flags
// [RULE12] Per-accumulator clipped flags on saturation
// [RULE13] Summary flags are ORs of pairs
// [RULE14] Guard flags follow each adder operation
// [RULE15] Guard flag with enable requests trap
// [RULE16] Clamp to 32-bit or 40-bit extremes
// [RULE17] Clipped flags sticky until software clears
`timescale 1ns/1ps
`include "acc_dp_defs.svh"
module acc_dp (
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic OP_VALID,
    input wire logic OP_SEL_B,
    input wire logic OP_SUB,
    input wire logic OP_LOAD,
    input wire logic OP_CARRY,
    input wire logic [`OPD_W-1:0] OP_DATA,
    input wire logic OP_SCALE_EN,
    input wire logic OP_SCALE_RIGHT,
    input wire logic [`SHAMT_W-1:0] OP_SCALE_AMT,
    input wire logic CLIP_ENABLE_A,
    input wire logic CLIP_ENABLE_B,
    input wire logic SAT_MODE_SELECT,
    input wire logic ACC_A_OVF_TRAP_EN,
    input wire logic ACC_B_OVF_TRAP_EN,
    input wire logic CLIP_FLAG_CLR,
    output logic [`ACC_MSB:0] ACCUMULATOR_A,
    output logic [`ACC_MSB:0] ACCUMULATOR_B,
    output logic ACC_A_GUARD_OVF,
    output logic ACC_B_GUARD_OVF,
    output logic ACC_A_CLIPPED_FLAG,
    output logic ACC_B_CLIPPED_FLAG,
    output logic ANY_GUARD_OVF_FLAG,
    output logic ANY_CLIP_FLAG,
    output logic SIGN_LOST_FLAG,
    output logic ARITH_TRAP_REQ
);

    ////////////////////////////////////////////////////////////////////
    // Functions

    // True when the top bits of a word are not all one value
    function automatic logic bits_mixed(input logic [`ACC_MSB:0] v,
                                        input int lo);
        logic all1;
        logic all0;
        all1 = 1'b1;
        all0 = 1'b1;
        for (int i = lo; i <= `ACC_MSB; i++) begin
            all1 = all1 & v[i];
            all0 = all0 & ~v[i];
        end
        return ~(all1 | all0);
    endfunction : bits_mixed

    // Extreme value of the chosen range with the given sign
    function automatic acc_dp_pkg::acc_type clamp_val(input logic neg,
                                                      input logic wide);
        if (wide) begin
            return neg ? `NEG40 : `POS40;
        end
        return neg ? `NEG32 : `POS32;
    endfunction : clamp_val

    ////////////////////////////////////////////////////////////////////
    // Reset release

    // Two-stage release so no flop leaves reset on a ragged edge
    logic rst_s1_q;
    logic rst_n;
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Operand path

    // Operand widened to accumulator width
    acc_dp_pkg::acc_type opd_ext;
    // Operand after optional scaling
    acc_dp_pkg::acc_type opd_scaled;
    // Shift applies only to add and load, never to subtract
    logic scale_on;

    // [RULE1] sign extension
    assign opd_ext = {{(`ACC_W-`OPD_W){OP_DATA[`OPD_W-1]}}, OP_DATA};
    // [RULE3] scale gating
    assign scale_on = OP_SCALE_EN & ~OP_SUB;
    // Arithmetic shift keeps the sign on right shifts
    assign opd_scaled = !scale_on ? opd_ext :
        OP_SCALE_RIGHT ? acc_dp_pkg::acc_type'($signed(opd_ext) >>> OP_SCALE_AMT) :
        (opd_ext << OP_SCALE_AMT);

    ////////////////////////////////////////////////////////////////////
    // Adder

    // Current contents of the selected accumulator
    acc_dp_pkg::acc_type acc_sel;
    // Accumulator side of the adder, zero on a load
    acc_dp_pkg::acc_type side_a;
    // Operand side, true or complemented
    acc_dp_pkg::acc_type side_b;
    // Carry into bit 0
    logic cin;
    // Raw adder output, one bit wider than the accumulator
    acc_dp_pkg::sum_type sum_w;

    // [RULE2] source selection
    assign acc_sel = OP_SEL_B ? ACCUMULATOR_B : ACCUMULATOR_A;
    // [RULE4] zero input
    assign side_a = OP_LOAD ? `ZERO40 : acc_sel;
    // [RULE4] true or complement
    assign side_b = OP_SUB ? ~opd_scaled : opd_scaled;
    // [RULE5] [RULE6] carry in, borrow when low
    // Borrow is active low, so a set carry on a subtract gives the plain difference
    // and a clear one takes one more off: the same wire feeds both operations
    assign cin = OP_CARRY;
    // Both sides extended by their sign so bit 40 holds the true sign
    assign sum_w = acc_dp_pkg::sum_type'({side_a[`ACC_MSB], side_a}
        + {side_b[`ACC_MSB], side_b} + {{(`SUM_W-1){1'b0}}, cin});

    ////////////////////////////////////////////////////////////////////
    // Overflow detection and saturation

    // Catastrophic overflow of the current operation
    logic sign_lost_w;
    // Guard bits disagree in the raw result
    logic guard_w;
    // Result leaves the 32-bit range, bit 31 included
    logic over32_w;
    // Saturation enabled for the selected accumulator
    logic clip_en_w;
    // Saturation actually applied
    logic sat_hit_w;
    // Value written back
    acc_dp_pkg::acc_type result_w;

    // [RULE7] sign destroyed
    assign sign_lost_w = sum_w[`SUM_W-1] ^ sum_w[`ACC_MSB];
    // Sign-rule view of the same overflow, read only by a check below
    logic ovf_ref_w;
    assign ovf_ref_w = (side_a[`ACC_MSB] == side_b[`ACC_MSB])
        & (sum_w[`ACC_MSB] != side_a[`ACC_MSB]);
    // [RULE8] guard bits unequal
    assign guard_w = bits_mixed(sum_w[`ACC_MSB:0], `GUARD_LO);
    assign over32_w = bits_mixed(sum_w[`ACC_MSB:0], `OPD_W-1) | sign_lost_w;
    assign clip_en_w = OP_SEL_B ? CLIP_ENABLE_B : CLIP_ENABLE_A;
    // [RULE10] normal mode clips at bit 31, wide mode at bit 39
    assign sat_hit_w = clip_en_w & (SAT_MODE_SELECT ? sign_lost_w : over32_w);
    // [RULE16] clamp toward the true sign held in bit 40
    assign result_w = sat_hit_w ? clamp_val(sum_w[`SUM_W-1], SAT_MODE_SELECT)
                                : sum_w[`ACC_MSB:0];

    ////////////////////////////////////////////////////////////////////
    // Next state

    // Strobe per accumulator for this operation
    logic wr_a;
    logic wr_b;
    assign wr_a = OP_VALID & ~OP_SEL_B;
    assign wr_b = OP_VALID & OP_SEL_B;

    logic guard_a_d;
    logic guard_b_d;
    logic clip_a_d;
    logic clip_b_d;
    logic trap_d;

    // [RULE14] guard flags rewritten only by the accumulator touched
    assign guard_a_d = wr_a ? guard_w : ACC_A_GUARD_OVF;
    assign guard_b_d = wr_b ? guard_w : ACC_B_GUARD_OVF;
    // [RULE17] a new clip beats a clear in the same cycle
    assign clip_a_d = (wr_a & sat_hit_w) | (ACC_A_CLIPPED_FLAG & ~CLIP_FLAG_CLR);
    assign clip_b_d = (wr_b & sat_hit_w) | (ACC_B_CLIPPED_FLAG & ~CLIP_FLAG_CLR);
    // [RULE15] trap request from a fresh guard overflow
    assign trap_d = guard_w & ((wr_a & ACC_A_OVF_TRAP_EN) | (wr_b & ACC_B_OVF_TRAP_EN));

    ////////////////////////////////////////////////////////////////////
    // Accumulators

    // [RULE2] destination written with the result
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            ACCUMULATOR_A <= `ZERO40;
            ACCUMULATOR_B <= `ZERO40;
        end else begin
            if (wr_a) begin
                ACCUMULATOR_A <= result_w;
            end
            if (wr_b) begin
                ACCUMULATOR_B <= result_w;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Status flags

    // [RULE9] [RULE11] [RULE12] [RULE13] flags latched as registers
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            ACC_A_GUARD_OVF <= 1'b0;
            ACC_B_GUARD_OVF <= 1'b0;
            ACC_A_CLIPPED_FLAG <= 1'b0;
            ACC_B_CLIPPED_FLAG <= 1'b0;
            ANY_GUARD_OVF_FLAG <= 1'b0;
            ANY_CLIP_FLAG <= 1'b0;
            SIGN_LOST_FLAG <= 1'b0;
            ARITH_TRAP_REQ <= 1'b0;
        end else begin
            ACC_A_GUARD_OVF <= guard_a_d;
            ACC_B_GUARD_OVF <= guard_b_d;
            ACC_A_CLIPPED_FLAG <= clip_a_d;
            ACC_B_CLIPPED_FLAG <= clip_b_d;
            // ORs taken from next values so they never lag a cycle
            ANY_GUARD_OVF_FLAG <= guard_a_d | guard_b_d;
            ANY_CLIP_FLAG <= clip_a_d | clip_b_d;
            // Shows the last operation only, like the guard flags
            if (OP_VALID) begin
                SIGN_LOST_FLAG <= sign_lost_w;
            end
            // One-cycle pulse per offending operation
            ARITH_TRAP_REQ <= trap_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!rst_n);

    any_guard_or_a: assert property ( // [RULE13]
        ANY_GUARD_OVF_FLAG == (ACC_A_GUARD_OVF | ACC_B_GUARD_OVF))
        else $error("guard summary differs from OR of flags");

    any_clip_or_a: assert property ( // [RULE13]
        ANY_CLIP_FLAG == (ACC_A_CLIPPED_FLAG | ACC_B_CLIPPED_FLAG))
        else $error("clip summary differs from OR of flags");

    other_acc_hold_a: assert property ( // [RULE2]
        wr_a |=> $stable(ACCUMULATOR_B) && $stable(ACC_B_GUARD_OVF))
        else $error("unselected accumulator changed");

    plain_add_a: assert property ( // [RULE5]
        wr_a && !OP_SUB && !OP_LOAD && !CLIP_ENABLE_A && !OP_SCALE_EN && !OP_CARRY
        |=> ACCUMULATOR_A == $past(ACCUMULATOR_A) + $past(opd_ext))
        else $error("add result wrong");

    plain_sub_a: assert property ( // [RULE6]
        wr_b && OP_SUB && !OP_LOAD && !CLIP_ENABLE_B && OP_CARRY
        |=> ACCUMULATOR_B == $past(ACCUMULATOR_B) - $past(opd_ext))
        else $error("subtract result wrong");

    guard_track_a: assert property ( // [RULE14]
        wr_a |=> ACC_A_GUARD_OVF == $past(guard_w))
        else $error("guard flag not from latest result");

    clip_sticky_a: assert property ( // [RULE17]
        ACC_A_CLIPPED_FLAG && !CLIP_FLAG_CLR |=> ACC_A_CLIPPED_FLAG [*1])
        else $error("clip flag dropped without clear");

    trap_req_a: assert property ( // [RULE15]
        wr_b && guard_w && ACC_B_OVF_TRAP_EN |=> ARITH_TRAP_REQ ##1 !ARITH_TRAP_REQ || $past(trap_d))
        else $error("trap request missing");

    clamp32_a: assert property ( // [RULE16]
        wr_a && CLIP_ENABLE_A && !SAT_MODE_SELECT && over32_w
        |=> ACCUMULATOR_A == ($past(sum_w[`SUM_W-1]) ? `NEG32 : `POS32) && ACC_A_CLIPPED_FLAG)
        else $error("32-bit clamp wrong");

    // [RULE7] sign loss from operand signs
    sign_lost_a: assert property ( // [RULE7]
        OP_VALID |=> SIGN_LOST_FLAG == $past(ovf_ref_w))
        else $error("sign loss flag wrong");

    // [RULE16] wide clamp on accumulator B
    clamp40_a: assert property ( // [RULE16]
        wr_b && CLIP_ENABLE_B && SAT_MODE_SELECT && sign_lost_w
        |=> ACCUMULATOR_B == ($past(sum_w[`SUM_W-1]) ? `NEG40 : `POS40) && ACC_B_CLIPPED_FLAG)
        else $error("40-bit clamp wrong");

    // [RULE15] no trap without operation
    trap_idle_a: assert property ( // [RULE15]
        !OP_VALID |=> !ARITH_TRAP_REQ)
        else $error("trap request without an operation");

endmodule : acc_dp

// *** acc_dp_defs.svh ***
// Constants for the 40-bit accumulator datapath.
// Assumes it is included by bare name from the design files.
`ifndef ACC_DP_DEFS_SVH
`define ACC_DP_DEFS_SVH
`define ACC_W 40
`define ACC_MSB 39
`define OPD_W 32
`define GUARD_LO 32
`define SHAMT_W 4
`define SUM_W 41
`define POS32 40'h007fffffff
`define NEG32 40'hff80000000
`define POS40 40'h7fffffffff
`define NEG40 40'h8000000000
`define ZERO40 40'h0000000000
`endif

// *** acc_dp_pkg.sv ***
// Types shared by the accumulator datapath.
// Assumes acc_dp_defs.svh is on the include path.
`include "acc_dp_defs.svh"
package acc_dp_pkg;
    // One accumulator word, guard bits included
    typedef logic [`ACC_MSB:0] acc_type;
    // Adder result with one extra bit for sign recovery
    typedef logic [`SUM_W-1:0] sum_type;
endpackage : acc_dp_pkg

// *** trap_sink.sv ***
// Core-side trap logic model: counts arithmetic warning requests.
// Assumes the request is a one-cycle pulse on clk.
`timescale 1ns/1ps
module trap_sink (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req,
    output int taken
);
    // Each high cycle is one trap taken by the core
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            taken <= 0;
        end else if (req) begin
            taken <= taken + 1;
        end
    end
endmodule : trap_sink

// *** acc_dp_tb_top.sv ***
// Self-checking bench for acc_dp: corner table, then random ops.
// Assumes acc_dp_pkg and trap_sink are compiled first.
`timescale 1ns/1ps
`include "acc_dp_defs.svh"
module acc_dp_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic vld = 1'b0, sel = 1'b0, sub = 1'b0, ld = 1'b0, cin = 1'b0;
    logic sen = 1'b0, srt = 1'b0, cea = 1'b0, ceb = 1'b0, mode = 1'b0;
    logic tea = 1'b0, teb = 1'b0, clr = 1'b0;
    logic [3:0] amt = 4'h0;
    logic [31:0] dat = 32'h0;
    acc_dp_pkg::acc_type acc_a, acc_b;
    logic ga, gb, ca, cb, gany, cany, lost, trap;
    int taken;
    // Mirror of the datapath state
    acc_dp_pkg::acc_type m_acc [2] = '{40'h0, 40'h0};
    logic [1:0] m_g = 2'h0, m_c = 2'h0;
    logic m_lost = 1'b0, m_trap = 1'b0;
    int m_traps = 0, err_count = 0, samples_checked = 0, cyc = 0;
    logic [31:0] seed = 32'h000112fe;
    // Corner ops: {clr,teb,tea,mode,ceb,cea,amt,srt,sen,cin,ld,sub,sel,vld}
    logic [16:0] cf [7] = '{17'h04429, 17'h02c21, 17'h10000, 17'h0000f,
        17'h0101f, 17'h007e3, 17'h12c21};
    logic [31:0] cd [7] = '{32'h7fffffff, 32'h7fffffff, 32'h0, 32'h80000000,
        32'h80000000, 32'h80000000, 32'h7fffffff};

    always #10 clk = ~clk;

    acc_dp i_dut (.CLK_SYS(clk), .RSTN(rst_n), .OP_VALID(vld), .OP_SEL_B(sel),
        .OP_SUB(sub), .OP_LOAD(ld), .OP_CARRY(cin), .OP_DATA(dat), .OP_SCALE_EN(sen),
        .OP_SCALE_RIGHT(srt), .OP_SCALE_AMT(amt), .CLIP_ENABLE_A(cea),
        .CLIP_ENABLE_B(ceb), .SAT_MODE_SELECT(mode), .ACC_A_OVF_TRAP_EN(tea),
        .ACC_B_OVF_TRAP_EN(teb), .CLIP_FLAG_CLR(clr), .ACCUMULATOR_A(acc_a),
        .ACCUMULATOR_B(acc_b), .ACC_A_GUARD_OVF(ga), .ACC_B_GUARD_OVF(gb),
        .ACC_A_CLIPPED_FLAG(ca), .ACC_B_CLIPPED_FLAG(cb), .ANY_GUARD_OVF_FLAG(gany),
        .ANY_CLIP_FLAG(cany), .SIGN_LOST_FLAG(lost), .ARITH_TRAP_REQ(trap));
    trap_sink i_trap (.clk(clk), .rst_n(rst_n), .req(trap), .taken(taken));

    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic chk(string name, logic [39:0] seen, logic [39:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Advance the mirror by the inputs now on the pins
    task automatic model_step();
        acc_dp_pkg::acc_type opd, cur, raw;
        logic [40:0] s;
        logic ovf, wide, c;
        int k;
        k = int'(sel);
        m_trap = 1'b0;
        // Clear first so a clip in the same cycle wins
        if (clr) m_c = 2'h0;
        if (!vld) return;
        opd = {{8{dat[31]}}, dat};
        if (sen && !sub && srt) opd = $signed(opd) >>> amt;
        if (sen && !sub && !srt) opd = opd << amt;
        if (sub) opd = ~opd;
        cur = ld ? 40'h0 : m_acc[k];
        s = {cur[39], cur} + {opd[39], opd} + {40'h0, cin};
        raw = s[39:0];
        ovf = s[40] ^ s[39];
        m_lost = ovf;
        m_g[k] = !(raw[39:32] == 8'h00 || raw[39:32] == 8'hff);
        wide = !(raw[39:31] == 9'h000 || raw[39:31] == 9'h1ff);
        c = (k == 1 ? ceb : cea) && (ovf || (!mode && wide));
        if (c && mode) raw = s[40] ? `NEG40 : `POS40;
        if (c && !mode) raw = s[40] ? `NEG32 : `POS32;
        if (c) m_c[k] = 1'b1;
        m_acc[k] = raw;
        m_trap = m_g[k] && (k == 1 ? teb : tea);
        m_traps += int'(m_trap);
    endtask : model_step

    // Check what the last edge left, then present new inputs
    task automatic step(logic [16:0] f, logic [31:0] d);
        @(negedge clk);
        chk("acc_a", acc_a, m_acc[0]);
        chk("acc_b", acc_b, m_acc[1]);
        chk("guard", 40'({gb, ga}), 40'(m_g));
        chk("clip", 40'({cb, ca}), 40'(m_c));
        chk("any", 40'({gany, cany}), 40'({|m_g, |m_c}));
        chk("lost", 40'(lost), 40'(m_lost));
        chk("trap", 40'(trap), 40'(m_trap));
        {clr, teb, tea, mode, ceb, cea, amt, srt, sen, cin, ld, sub, sel, vld} = f;
        dat = d;
        model_step();
    endtask : step

    task automatic end_sim();
        if (err_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    ////////////////////////////////////////////////////////////
    // Hang guard, well above the 3009 steps of the run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 10000) begin
            err_count++;
            end_sim();
        end
    end

    // Reset, corner table, random traffic, trap count
    initial begin
        logic [31:0] r;
        repeat (20) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 7; i++) begin
            step(cf[i], cd[i]);
        end
        for (int i = 0; i < 3000; i++) begin
            r = rnd();
            r[16] = r[16] & (r[31:28] == 4'h0);
            step(r[16:0], rnd());
        end
        step(17'h0, 32'h0);
        step(17'h0, 32'h0);
        chk("traps", 40'(taken), 40'(m_traps));
        end_sim();
    end
endmodule : acc_dp_tb_top
